// ==== hw/fppc_decoder.sv ====
`timescale 1ns/10ps
`include "fppc_cfg.svh"
// Overview of operation
// - There are 32 predicates in two groups of 16, one raising an exception when unordered.
// - A condition is unordered whenever any input of the setting operation was a NaN.
// - Conditional instructions decide on the status register condition codes last set.
// - The conditional branch adds the displacement to the PC only when the predicate is true.
// - Decrement-and-branch does nothing when true, else decrements and branches unless minus one.
// - The conditional set writes all ones to a byte when true and all zeros when false.
// - The test operation updates only the condition codes from its operand.
// - The no-operation computes nothing and holds the main processor until prior work ends.
// - The conditional trap uses the same predicates, traps when true and passes its immediate.
// - Save dumps the condition codes and exception flag into a frame and restore reloads only the condition codes from one.
// - The dual sine/cosine sends sine to one named register and cosine to another.
// - The monadic decoder supports the twelve listed log, trig and power functions.
// - Memory operands are 96-bit extended reals with 16 unused bits.
module fppc_decoder (
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire logic                 req_valid,
  input  wire fppc_pkg::fppc_req_t  req,
  input  wire fppc_pkg::fppc_cc_upd_t cc_upd,
  input  wire logic                 arith_busy,
  output logic                      req_ready,
  output fppc_pkg::fppc_rsp_t       rsp,
  output logic [3:0]                fp_status_register,
  output logic                      unordered_exc
);
  import fppc_pkg::*;

  typedef enum logic [1:0] {
    FPPC_IDLE = 2'b00,
    FPPC_EXC  = 2'b01,
    FPPC_SYNC = 2'b10
  } fppc_state_t;

  fppc_state_t state_q;
  fppc_rsp_t   rsp_q;
  fppc_rsp_t   rsp_d;
  logic [3:0]  cc_q;
  logic        exc_q;
  logic        pred_true;
  logic        pred_exc;
  logic        take;
  logic [15:0] cnt_dec;

  // Predicate equations on the low four code bits; the signaling bit only adds the exception.
  function automatic logic pred_eval(input logic [3:0] code, input logic [3:0] cc);
    logic n, z, u;
    n = cc[`FPPC_CC_N];
    z = cc[`FPPC_CC_Z];
    u = cc[`FPPC_CC_NAN];
    unique case (code)
      4'h0: pred_eval = 1'b0;
      4'h1: pred_eval = z;
      4'h2: pred_eval = ~(u | z | n);
      4'h3: pred_eval = z | ~(u | n);
      4'h4: pred_eval = n & ~(u | z);
      4'h5: pred_eval = z | (n & ~u);
      4'h6: pred_eval = ~(u | z);
      4'h7: pred_eval = ~u;
      4'h8: pred_eval = u;
      4'h9: pred_eval = u | z;
      4'ha: pred_eval = u | ~(n | z);
      4'hb: pred_eval = u | z | ~n;
      4'hc: pred_eval = u | (n & ~z);
      4'hd: pred_eval = u | z | n;
      4'he: pred_eval = ~z;
      4'hf: pred_eval = 1'b1;
    endcase
  endfunction : pred_eval

  // Class of a 96-bit extended operand as condition codes; the 16 unused bits are ignored.
  function automatic logic [3:0] ext_class(input logic [95:0] x);
    logic        ones, frac;
    logic [3:0]  c;
    ones = &x[`FPPC_EXP_HI-1:`FPPC_EXP_LO];
    frac = |x[`FPPC_MANT_HI-1:0];
    c = 4'h0;
    c[`FPPC_CC_N]   = x[`FPPC_EXP_HI];
    c[`FPPC_CC_Z]   = ~(|x[`FPPC_EXP_HI-1:`FPPC_EXP_LO]) & ~(|x[`FPPC_MANT_HI:0]);
    c[`FPPC_CC_I]   = ones & ~frac;
    c[`FPPC_CC_NAN] = ones & frac;
    ext_class = c;
  endfunction : ext_class

  assign take      = req_valid && state_q == FPPC_IDLE;
  assign pred_true = pred_eval(req.pred[3:0], cc_q);
  assign pred_exc  = req.pred[`FPPC_PRED_SIG] && cc_q[`FPPC_CC_NAN];
  assign cnt_dec   = req.loop_counter_reg - 16'h0001;

  always_comb
  begin
    rsp_d = '0;
    rsp_d.func = FPPC_NONE;
    rsp_d.next_pc = req.seq_pc;
    rsp_d.done = take && req.op != FPPC_SYNC_NOOP;
    unique case (req.op)
      FPPC_COND_BRANCH:
      begin
        if (pred_true)
        begin
          rsp_d.next_pc = req.pc + req.disp;
        end
      end
      FPPC_DEC_BRANCH:
      begin
        if (!pred_true)
        begin
          rsp_d.counter_wr = 1'b1;
          rsp_d.loop_counter_reg = cnt_dec;
          if (cnt_dec != `FPPC_CNT_END)
          begin
            rsp_d.next_pc = req.pc + req.disp;
          end
        end
      end
      FPPC_SET_BYTE:
      begin
        rsp_d.byte_wr = 1'b1;
        rsp_d.byte_val = pred_true ? `FPPC_ONES_BYTE : `FPPC_ZERO_BYTE;
      end
      FPPC_COND_TRAP:
      begin
        rsp_d.trap = pred_true;
        rsp_d.trap_param = req.imm;
      end
      FPPC_STATE_DUMP:
      begin
        rsp_d.frame_wr = 1'b1;
        rsp_d.frame = {12'h000, cc_q, {`FPPC_EXT_UNUSED{1'b0}}, 63'h0, exc_q};
      end
      FPPC_MONADIC:
      begin
        rsp_d.func_wr = req.mfunc <= FPPC_TWOTOX;
        rsp_d.func = (req.mfunc <= FPPC_TWOTOX) ? req.mfunc : FPPC_NONE;
      end
      FPPC_DUAL_SINCOS:
      begin
        rsp_d.func_wr = 1'b1;
        rsp_d.func = FPPC_SINCOS;
        rsp_d.dual = 1'b1;
        rsp_d.sine_dest_reg = req.sine_dest_reg;
        rsp_d.cosine_dest_reg = req.cosine_dest_reg;
      end
      default:
      begin
      end
    endcase
  end

  // A signaling predicate on unordered codes is held back one cycle behind its exception.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= FPPC_IDLE;
      rsp_q   <= '0;
      exc_q   <= 1'b0;
    end
    else
    begin
      exc_q <= 1'b0;
      rsp_q <= '0;
      unique case (state_q)
        FPPC_IDLE:
        begin
          if (take && req.op == FPPC_SYNC_NOOP)
          begin
            rsp_q   <= rsp_d;
            state_q <= FPPC_SYNC;
          end
          else if (take && pred_exc && req.op inside {FPPC_COND_BRANCH, FPPC_DEC_BRANCH,
                                                      FPPC_SET_BYTE, FPPC_COND_TRAP})
          begin
            exc_q   <= 1'b1;
            rsp_q   <= rsp_d;
            rsp_q.done <= 1'b0;
            state_q <= FPPC_EXC;
          end
          else if (take)
          begin
            rsp_q <= rsp_d;
          end
        end
        FPPC_EXC:
        begin
          rsp_q      <= rsp_q;
          rsp_q.done <= 1'b1;
          state_q    <= FPPC_IDLE;
        end
        FPPC_SYNC:
        begin
          rsp_q <= rsp_q;
          if (!arith_busy)
          begin
            rsp_q.done <= 1'b1;
            state_q    <= FPPC_IDLE;
          end
        end
        default:
        begin
          state_q <= FPPC_IDLE;
        end
      endcase
    end
  end

  // Restore outranks test, which outranks an arithmetic update in the same cycle.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cc_q <= `FPPC_CC_RESET;
    end
    else if (take && req.op == FPPC_STATE_RELOAD)
    begin
      cc_q <= req.operand[`FPPC_SEXP_LO+3:`FPPC_SEXP_LO];
    end
    else if (take && req.op == FPPC_TEST_OPERAND)
    begin
      cc_q <= ext_class(req.operand);
    end
    else if (cc_upd.valid)
    begin
      cc_q <= {cc_upd.neg, cc_upd.zero, cc_upd.inf, cc_upd.nan_in};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_ready <= 1'b0;
    end
    else
    begin
      req_ready <= state_q == FPPC_IDLE && !take;
    end
  end

  assign rsp                = rsp_q;
  assign fp_status_register = cc_q;
  assign unordered_exc      = exc_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_sig_unordered;
    take && pred_exc && req.op == FPPC_COND_BRANCH;
  endsequence

  property p_exc_first;
    s_sig_unordered |=> unordered_exc && !rsp.done ##1 rsp.done && !unordered_exc;
  endproperty
  a_exc_first: assert property (p_exc_first) else $error("late unordered exception");

  property p_branch;
    take && !pred_exc && req.op == FPPC_COND_BRANCH
      |=> rsp.done && rsp.next_pc == ($past(pred_true) ? $past(req.pc) + $past(req.disp)
                                                         : $past(req.seq_pc));
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");
  property p_dec;
    take && !pred_exc && req.op == FPPC_DEC_BRANCH && !pred_true
      |=> rsp.counter_wr && rsp.loop_counter_reg == $past(req.loop_counter_reg) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("counter not decremented");
  property p_dec_true;
    take && !pred_exc && req.op == FPPC_DEC_BRANCH && pred_true |=> !rsp.counter_wr;
  endproperty
  a_dec_true: assert property (p_dec_true) else $error("counter touched when true");

  property p_set;
    take && !pred_exc && req.op == FPPC_SET_BYTE
      |=> rsp.byte_val == ($past(pred_true) ? 8'hff : 8'h00);
  endproperty
  a_set: assert property (p_set) else $error("set byte value wrong");

  property p_nan;
    cc_upd.valid && cc_upd.nan_in && !take |=> fp_status_register[0];
  endproperty
  a_nan: assert property (p_nan) else $error("NaN input not unordered");

  property p_sync;
    (take && req.op == FPPC_SYNC_NOOP) || (state_q == FPPC_SYNC && arith_busy) |=> !rsp.done;
  endproperty
  a_sync: assert property (p_sync) else $error("sync finished while busy");
  property p_quiet;
    take && !req.pred[4] |=> !unordered_exc;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet predicate raised");

  property p_trap;
    take && !pred_exc && req.op == FPPC_COND_TRAP |=> rsp.trap == $past(pred_true);
  endproperty
  a_trap: assert property (p_trap) else $error("trap mismatch");
endmodule : fppc_decoder

// ==== shared/fppc_cfg.svh ====
`ifndef FPPC_CFG_SVH
`define FPPC_CFG_SVH
// Condition code bit positions inside the four-bit status register.
`define FPPC_CC_N       3
`define FPPC_CC_Z       2
`define FPPC_CC_I       1
`define FPPC_CC_NAN     0
`define FPPC_CC_RESET   4'h0
`define FPPC_NUM_PRED   32
`define FPPC_GROUP_SIZE 16
// Predicate code bit that selects the group raising an exception on unordered.
`define FPPC_PRED_SIG   4
// Extended real memory operand: 96 bits with 16 unused.
`define FPPC_EXT_BITS   96
`define FPPC_EXT_UNUSED 16
`define FPPC_EXP_HI     95
`define FPPC_SEXP_LO    80
`define FPPC_EXP_LO     80
`define FPPC_EXP_W      15
`define FPPC_MANT_HI    63
`define FPPC_ONES_BYTE  8'hff
`define FPPC_ZERO_BYTE  8'h00
`define FPPC_CNT_END    16'hffff
`endif

// ==== shared/fppc_pkg.sv ====
package fppc_pkg;
  typedef enum logic [3:0] {
    FPPC_COND_BRANCH  = 4'h0,
    FPPC_DEC_BRANCH   = 4'h1,
    FPPC_SET_BYTE     = 4'h2,
    FPPC_TEST_OPERAND = 4'h3,
    FPPC_SYNC_NOOP    = 4'h4,
    FPPC_COND_TRAP    = 4'h5,
    FPPC_STATE_DUMP   = 4'h6,
    FPPC_STATE_RELOAD = 4'h7,
    FPPC_MONADIC      = 4'h8,
    FPPC_DUAL_SINCOS  = 4'h9
  } fppc_opcode_t;

  typedef enum logic [3:0] {
    FPPC_LOGN   = 4'h0,
    FPPC_LOGNP1 = 4'h1,
    FPPC_LOG10  = 4'h2,
    FPPC_LOG2   = 4'h3,
    FPPC_NEG    = 4'h4,
    FPPC_SIN    = 4'h5,
    FPPC_SINH   = 4'h6,
    FPPC_SQRT   = 4'h7,
    FPPC_TAN    = 4'h8,
    FPPC_TANH   = 4'h9,
    FPPC_TENTOX = 4'ha,
    FPPC_TWOTOX = 4'hb,
    FPPC_SINCOS = 4'hc,
    FPPC_NONE   = 4'hf
  } fppc_mfunc_t;

  typedef struct packed {
    fppc_opcode_t op;
    logic [4:0]   pred;
    logic [31:0]  pc;
    logic [31:0]  seq_pc;
    logic [31:0]  disp;
    logic [15:0]  loop_counter_reg;
    logic [95:0]  operand;
    fppc_mfunc_t  mfunc;
    logic [2:0]   sine_dest_reg;
    logic [2:0]   cosine_dest_reg;
    logic [31:0]  imm;
  } fppc_req_t;

  typedef struct packed {
    logic valid;
    logic nan_in;
    logic neg;
    logic zero;
    logic inf;
  } fppc_cc_upd_t;

  typedef struct packed {
    logic         done;
    logic [31:0]  next_pc;
    logic         counter_wr;
    logic [15:0]  loop_counter_reg;
    logic         byte_wr;
    logic [7:0]   byte_val;
    logic         trap;
    logic [31:0]  trap_param;
    logic         frame_wr;
    logic [95:0]  frame;
    logic         func_wr;
    fppc_mfunc_t  func;
    logic         dual;
    logic [2:0]   sine_dest_reg;
    logic [2:0]   cosine_dest_reg;
  } fppc_rsp_t;
endpackage : fppc_pkg

// ==== verification/fppc_host_model.sv ====
`timescale 1ns/10ps
module fppc_host_model (
  input  wire logic                core_clk,
  output logic                     req_valid,
  output fppc_pkg::fppc_req_t      req
);
  import fppc_pkg::*;

  initial
  begin
    req_valid = 1'b0;
    req       = '0;
  end

  // One request is offered over exactly one rising edge, because a held valid repeats it.
  task automatic send(input fppc_req_t r);
    @(negedge core_clk);
    req_valid = 1'b1;
    req       = r;
    @(negedge core_clk);
    req_valid = 1'b0;
    // Released fields show the inverse so that nothing leans on stale values.
    req       = ~r;
  endtask : send
endmodule : fppc_host_model

// ==== verification/fppc_decoder_tb.sv ====
`timescale 1ns/10ps
module fppc_decoder_tb;
  import fppc_pkg::*;
  typedef struct packed {logic [2:0] sel; logic exc; logic [31:0] val; logic [31:0] val2;} fppc_note_t;
  logic         core_clk   = 1'b0;
  logic         reset_n    = 1'b0;
  logic         req_valid;
  fppc_req_t    req;
  fppc_cc_upd_t cc_upd     = '0;
  logic         arith_busy = 1'b0;
  fppc_rsp_t    rsp;
  logic [3:0]   fp_status_register;
  logic         req_ready;
  logic         unordered_exc;
  int           err_total       = 0;
  int           samples_checked = 0;
  logic [31:0]  rs         = 32'h0000_5a19;
  logic         exc_seen   = 1'b0;
  fppc_note_t   q[$];
  fppc_note_t   n;
  fppc_note_t   e;
  fppc_req_t    r;
  logic [31:0]  x;
  logic [3:0]   cc;
  logic         t;
  logic [15:0]  c1;
  logic [287:0] w;

  always #5 core_clk = ~core_clk;

  fppc_decoder fppc_decoder_i (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .cc_upd(cc_upd), .arith_busy(arith_busy), .req_ready(req_ready),
    .rsp(rsp), .fp_status_register(fp_status_register), .unordered_exc(unordered_exc));
  fppc_host_model fppc_host_model_i (.core_clk(core_clk), .req_valid(req_valid), .req(req));

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  // Codes 8..15 are the complements of codes 7..0, so only half is tabled; codes 8..13 are
  // the unordered-or forms and so also hold whenever the unordered bit is set.
  function automatic logic ptrue(input logic [3:0] p, input logic [3:0] c);
    logic [7:0] f;
    logic [3:0] k;
    k = p[3] ? ~p : p;
    f = {~c[0], ~(c[0] | c[2]), c[2] | (c[3] & ~c[0]), c[3] & ~(c[0] | c[2]),
         c[2] | ~(c[0] | c[3]), ~(c[0] | c[2] | c[3]), c[2], 1'b0};
    return (p[3] ^ f[k[2:0]]) | (p[3] & ~(p[2] & p[1]) & c[0]);
  endfunction : ptrue

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (!ok)
    begin
      err_total++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic run(input fppc_note_t en);
    q.push_back(en);
    fppc_host_model_i.send(r);
    for (int i = 0; i < 40 && q.size() != 0; i++)
      @(negedge core_clk);
    chk(q.size() == 0, "no completion");
  endtask : run

  always @(negedge core_clk)
  begin
    if (unordered_exc === 1'b1)
      exc_seen = 1'b1;
    if (rsp.done === 1'b1 && q.size() == 0)
      chk(1'b0, "unexpected completion");
    else if (rsp.done === 1'b1)
    begin
      n = q.pop_front();
      chk(exc_seen === n.exc, "unordered flag");
      exc_seen = 1'b0;
      case (n.sel)
        3'h0: chk(rsp.next_pc === n.val, "next pc");
        3'h1: chk(rsp.next_pc === n.val && rsp.counter_wr === n.val2[16] && (!n.val2[16] ||
                  rsp.loop_counter_reg === n.val2[15:0]), "decrement branch");
        3'h2: chk(rsp.byte_wr === 1'b1 && rsp.byte_val === n.val[7:0], "set byte");
        3'h3: chk(rsp.trap === n.val[0] && (!n.val[0] || rsp.trap_param === n.val2), "trap");
        3'h4: chk(rsp.func_wr === n.val[4] && rsp.func === n.val[3:0], "monadic");
        3'h5: chk(rsp.dual === 1'b1 && rsp.func === FPPC_SINCOS &&
                  {rsp.sine_dest_reg, rsp.cosine_dest_reg} === n.val2[5:0],
                  "dual");
        3'h6: chk(rsp.frame_wr === 1'b1 && rsp.frame[83:80] === n.val[3:0], "frame");
        default: ;
      endcase
    end
  end

  initial
  begin
    #60000;
    chk(1'b0, "watchdog");
    stop_test();
  end

  initial
  begin
    r = '0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 80; i++)
    begin
      x = rnd();
      cc = x[3:0];
      cc_upd = {1'b1, cc[0], cc[3], cc[2], cc[1]};
      @(negedge core_clk);
      cc_upd.valid = 1'b0;
      @(negedge core_clk);
      chk(fp_status_register === cc, "condition codes");
      w = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      r = w[$bits(fppc_req_t)-1:0];
      r.pred = x[8:4];
      r.loop_counter_reg = x[9] ? 16'h0000 : x[31:16];
      r.op = (x[11:10] == 2'h3) ? FPPC_COND_TRAP : fppc_opcode_t'({2'h0, x[11:10]});
      t = ptrue(r.pred[3:0], cc);
      c1 = r.loop_counter_reg - 16'h0001;
      e = {x[11:10] == 2'h3 ? 3'h3 : {1'b0, x[11:10]}, r.pred[4] & cc[0], 64'h0};
      case (r.op)
        FPPC_COND_BRANCH: e.val = t ? r.pc + r.disp : r.seq_pc;
        FPPC_DEC_BRANCH:
        begin
          e.val = (t || c1 == 16'hffff) ? r.seq_pc : r.pc + r.disp;
          e.val2 = t ? 32'h0 : {15'h0, 1'b1, c1};
        end
        FPPC_SET_BYTE: e.val = t ? 32'hff : 32'h00;
        default:
        begin
          e.val = {31'h0, t};
          e.val2 = r.imm;
        end
      endcase
      run(e);
    end
    $display("test predicates done");
    r.pred = 5'h00;
    // The thirteenth code is the dual form, which the plain monadic path must refuse.
    for (int m = 0; m < 13; m++)
    begin
      r.op = FPPC_MONADIC;
      r.mfunc = fppc_mfunc_t'(m[3:0]);
      run({3'h4, 1'b0, 27'h0, m < 12, m < 12 ? m[3:0] : FPPC_NONE, 32'h0});
    end
    r.op = FPPC_DUAL_SINCOS;
    run({3'h5, 1'b0, 32'h0, 26'h0, r.sine_dest_reg, r.cosine_dest_reg});
    r.op = FPPC_STATE_DUMP;
    run({3'h6, 1'b0, 28'h0, cc, 32'h0});
    r.op = FPPC_STATE_RELOAD;
    r.operand[83:80] = 4'ha;
    run({3'h7, 33'h0, 32'h0});
    chk(fp_status_register === 4'ha, "reload");
    $display("test functions done");
    r.op = FPPC_TEST_OPERAND;
    for (int k = 0; k < 4; k++)
    begin
      // The unused middle bits are set throughout, since the class must not depend on them.
      r.operand = {k == 1, k == 0 ? 15'h0 : k == 1 ? 15'h3fff : 15'h7fff, 16'hffff, k != 0,
                   k == 3 ? 63'h1 : 63'h0};
      run({3'h7, 33'h0, 32'h0});
      chk(fp_status_register === (k == 0 ? 4'h4 : k == 1 ? 4'h8 : k == 2 ? 4'h2 : 4'h1),
          "test codes");
    end
    arith_busy = 1'b1;
    r.op = FPPC_SYNC_NOOP;
    q.push_back({3'h7, 33'h0, 32'h0});
    fppc_host_model_i.send(r);
    repeat (5) @(negedge core_clk);
    chk(q.size() == 1, "noop finished early");
    chk(req_ready === 1'b0, "ready while syncing");
    arith_busy = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(q.size() == 0, "noop hung");
    chk(req_ready === 1'b1, "not ready after sync");
    $display("test control done");
    stop_test();
  end
endmodule : fppc_decoder_tb
